// ### ees_pkg.sv
package ees_pkg;
  // ==================================================
  // array geometry
  localparam int ADDR_W     = 16;
  localparam int PAGE_W     = 7;
  localparam int PAGE_BYTES = 128;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  // ==================================================
  // instruction codes
  localparam logic [7:0] CMD_READ               = 8'h03;
  localparam logic [7:0] CMD_WRITE              = 8'h02;
  localparam logic [7:0] CMD_SET_WRITE_LATCH    = 8'h06;
  localparam logic [7:0] CMD_CLEAR_WRITE_LATCH  = 8'h04;
  localparam logic [7:0] CMD_READ_STATUS        = 8'h05;
  localparam logic [7:0] CMD_WRITE_STATUS       = 8'h01;
  localparam logic [7:0] CMD_PAGE_ERASE         = 8'h42;
  localparam logic [7:0] CMD_ZONE_CLEAR         = 8'hd8;
  localparam logic [7:0] CMD_CHIP_ERASE         = 8'hc7;
  localparam logic [7:0] CMD_WAKE_AND_SIGNATURE = 8'hab;
  localparam logic [7:0] CMD_SLEEP_DEEP         = 8'hb9;

  // ==================================================
  // status byte layout and reset values
  localparam int SR_BUSY_BIT = 0;
  localparam int SR_WEL_BIT  = 1;
  localparam int SR_BP_LO    = 2;
  localparam int SR_BP_HI    = 3;
  localparam int SR_PPE_BIT  = 7;
  localparam logic [1:0] BP_RESET  = 2'h0;
  localparam logic       PPE_RESET = 1'b0;

  // ==================================================
  // timing
  localparam int CLK_FREQ_HZ      = 50_000_000;
  localparam int WRITE_CYCLE_MS   = 5;
  localparam int WRITE_CYCLE_CLKS = WRITE_CYCLE_MS * (CLK_FREQ_HZ / 1000);

  typedef enum logic [3:0] {
    ST_IDLE, ST_OP, ST_ADDR, ST_WDATA, ST_RDATA, ST_STAT, ST_WSR, ST_DONE, ST_IGN
  } ees_state_type;
endpackage

// ### ees_spi_eeprom.sv
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - chip select low selects, high gives standby once no write cycle runs
// - started programming cycle always runs to end
// - output high impedance while deselected
// - select rise after valid write starts cycle
// - sample input on rise, shift out on fall
// - protect pin plus enable bit blocks status write
// - protect pin change ignored once cycle runs
// - enable bit clear makes protect pin ignored
// - pause suspends sequence, clock-low aware start
// - paused device ignores clock and input
// - resume at once if clock low, else fall
// - pause edges switch output enable directly
// - eight-bit instruction, everything msb first
// - decode read, write, set and clear latch
// - decode status read/write; set-latch sets latch
// - decode page erase; zone clear, chip erase, signature and sleep do nothing
// - sequential read streams and rolls over
// - write up to one page; rest refreshed
// - page write wraps within its page
// - write only on select rise after D0
// - status readable during cycle, array not
// - status bits busy, latch, protect, enable
// - internal write cycle lasts at most 5 ms
module ees_spi_eeprom #(
  parameter int TWC_CYCLES = ees_pkg::WRITE_CYCLE_CLKS
) (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic cs_n,
  input  wire logic sck,
  input  wire logic si,
  input  wire logic hold_n,
  input  wire logic wp_n,
  output var  logic so,
  output var  logic so_oe_n,
  output var  logic standby
);
  import ees_pkg::*;

  localparam int TW = $clog2(TWC_CYCLES + 1);

  // ==================================================
  // pin synchronisers: cs, sck, si, hold, wp
  logic [4:0] meta_r;
  logic [4:0] sync_r;
  logic       cs_d_r;
  logic       sck_d_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      // idle pin levels, so no false clock edge follows reset
      meta_r  <= 5'h19;
      sync_r  <= 5'h19;
      cs_d_r  <= 1'b1;
      sck_d_r <= 1'b0;
    end else begin
      meta_r  <= {wp_n, hold_n, si, sck, cs_n};
      sync_r  <= meta_r;
      cs_d_r  <= sync_r[0];
      sck_d_r <= sync_r[1];
    end
  end

  logic cs_s, sck_s, si_s, hold_s, wp_s;
  assign cs_s   = sync_r[0];
  assign sck_s  = sync_r[1];
  assign si_s   = sync_r[2];
  assign hold_s = sync_r[3];
  assign wp_s   = sync_r[4];

  logic cs_fall, cs_rise, sck_rise, sck_fall;
  assign cs_fall  = cs_d_r & ~cs_s;
  assign cs_rise  = ~cs_d_r & cs_s;
  assign sck_rise = ~sck_d_r & sck_s;
  assign sck_fall = sck_d_r & ~sck_s;

  // ==================================================
  // storage
  logic [7:0] mem  [0:(1 << ADDR_W) - 1];
  logic [7:0] pbuf [0:PAGE_BYTES - 1];

  function automatic logic blocked(input logic [15:0] a, input logic [1:0] bp);
    case (bp)
      2'h1:    blocked = a[15] & a[14];
      2'h2:    blocked = a[15];
      2'h3:    blocked = 1'b1;
      default: blocked = 1'b0;
    endcase
  endfunction

  // ==================================================
  // command engine
  ees_state_type           state_r, state_nxt;
  logic [2:0]              bcnt_r, bcnt_nxt;
  logic [7:0]              sh_r, sh_nxt, op_r, op_nxt, out_r, out_nxt;
  logic                    abyte_r, abyte_nxt, done_r, done_nxt;
  logic [ADDR_W-1:0]       addr_r, addr_nxt;
  logic [PAGE_W-1:0]       col_r, col_nxt;
  logic                    paused_r, paused_nxt;
  logic                    wel_r, wel_nxt, wip_r, wip_nxt, erase_r, erase_nxt;
  logic                    ppe_r, ppe_nxt;
  logic [1:0]              bp_r, bp_nxt;
  logic [TW-1:0]           tmr_r, tmr_nxt;
  logic [PAGE_W:0]         cidx_r, cidx_nxt;
  logic [PAGE_BYTES-1:0]   pvalid_r, pvalid_nxt;
  logic                    so_nxt, so_oe_n_nxt, standby_nxt;
  logic                    mem_we, pbuf_we;
  logic [ADDR_W-1:0]       mem_wa;
  logic [7:0]              mem_wd;
  logic [7:0]              byte_in, status;
  logic [ADDR_W-1:0]       full_addr;
  logic                    live, edge_ok;

  always_comb begin
    status = 8'h00;
    status[SR_BUSY_BIT] = wip_r;
    status[SR_WEL_BIT]  = wel_r;
    status[SR_BP_HI:SR_BP_LO] = bp_r;
    status[SR_PPE_BIT]  = ppe_r;
    byte_in   = {sh_r[6:0], si_s};
    full_addr = {addr_r[15:8], byte_in};
    state_nxt = state_r;  bcnt_nxt = bcnt_r;  sh_nxt = sh_r;  op_nxt = op_r;
    out_nxt = out_r;  abyte_nxt = abyte_r;  done_nxt = done_r;  addr_nxt = addr_r;
    col_nxt = col_r;  paused_nxt = paused_r;  wel_nxt = wel_r;  wip_nxt = wip_r;
    erase_nxt = erase_r;  ppe_nxt = ppe_r;  bp_nxt = bp_r;  tmr_nxt = tmr_r;
    cidx_nxt = cidx_r;  pvalid_nxt = pvalid_r;  so_nxt = so;
    mem_we = 1'b0;  mem_wa = {addr_r[15:7], cidx_r[PAGE_W-1:0]};
    mem_wd = erase_r ? ERASED_BYTE : pbuf[cidx_r[PAGE_W-1:0]];
    pbuf_we = 1'b0;
    live = !cs_s && state_r != ST_IDLE;

    // pause engages or releases when the clock is low, else on its fall
    if (!live) begin
      paused_nxt = 1'b0;
    end else if ((hold_s == paused_r) && (!sck_s || sck_fall)) begin
      paused_nxt = !hold_s;
    end
    edge_ok = live && !paused_r && !paused_nxt;

    // self-timed cycle, one page byte committed per clock at the start
    if (wip_r) begin
      if (!cidx_r[PAGE_W]) begin
        mem_we   = erase_r | pvalid_r[cidx_r[PAGE_W-1:0]];
        cidx_nxt = cidx_r + 1'b1;
      end
      tmr_nxt = tmr_r + 1'b1;
      if (tmr_r == TW'(TWC_CYCLES - 1)) begin
        wip_nxt    = 1'b0;
        wel_nxt    = 1'b0;
        pvalid_nxt = '0;
      end
    end

    if (cs_fall) begin
      state_nxt = ST_OP;
      bcnt_nxt  = 3'd0;
      done_nxt  = 1'b0;
      if (!wip_r) pvalid_nxt = '0;
    end else if (cs_rise) begin
      state_nxt = ST_IDLE;
      if (done_r && !wip_r) begin
        case (op_r)
          CMD_SET_WRITE_LATCH:   wel_nxt = 1'b1;
          CMD_CLEAR_WRITE_LATCH: wel_nxt = 1'b0;
          CMD_WRITE_STATUS: begin
            if (wel_r && !(ppe_r && !wp_s)) begin
              ppe_nxt  = out_r[SR_PPE_BIT];
              bp_nxt   = out_r[SR_BP_HI:SR_BP_LO];
              wip_nxt  = 1'b1;
              tmr_nxt  = '0;
              cidx_nxt = {1'b1, {PAGE_W{1'b0}}};
            end
          end
          CMD_WRITE, CMD_PAGE_ERASE: begin
            if (wel_r && !blocked(addr_r, bp_r)) begin
              wip_nxt   = 1'b1;
              tmr_nxt   = '0;
              cidx_nxt  = '0;
              erase_nxt = (op_r == CMD_PAGE_ERASE);
            end
          end
          default: ;
        endcase
      end
    end else if (edge_ok && sck_rise) begin
      sh_nxt   = byte_in;
      bcnt_nxt = bcnt_r + 3'd1;
      done_nxt = 1'b0;
      if (state_r == ST_DONE) state_nxt = ST_IGN;
      if (bcnt_r == 3'd7) begin
        case (state_r)
          ST_OP: begin
            op_nxt    = byte_in;
            abyte_nxt = 1'b0;
            if (wip_r && byte_in != CMD_READ_STATUS) begin
              state_nxt = ST_IGN;
            end else begin
              case (byte_in)
                CMD_READ, CMD_WRITE, CMD_PAGE_ERASE, CMD_ZONE_CLEAR: state_nxt = ST_ADDR;
                CMD_SET_WRITE_LATCH, CMD_CLEAR_WRITE_LATCH, CMD_CHIP_ERASE: begin
                  state_nxt = ST_DONE;
                  done_nxt  = 1'b1;
                end
                CMD_READ_STATUS: begin
                  state_nxt = ST_STAT;
                  out_nxt   = status;
                end
                CMD_WRITE_STATUS: state_nxt = ST_WSR;
                default: state_nxt = ST_IGN;  // signature and sleep not modelled
              endcase
            end
          end
          ST_ADDR: begin
            if (!abyte_r) begin
              addr_nxt[15:8] = byte_in;
              abyte_nxt      = 1'b1;
            end else begin
              addr_nxt = full_addr;
              col_nxt  = byte_in[PAGE_W-1:0];
              case (op_r)
                CMD_READ: begin
                  state_nxt = ST_RDATA;
                  out_nxt   = mem[full_addr];
                end
                CMD_WRITE: state_nxt = ST_WDATA;
                default: begin
                  state_nxt = ST_DONE;
                  done_nxt  = 1'b1;
                end
              endcase
            end
          end
          ST_WDATA: begin
            pbuf_we             = 1'b1;
            pvalid_nxt[col_r]   = 1'b1;
            col_nxt             = col_r + 1'b1;
            done_nxt            = 1'b1;
          end
          ST_WSR: begin
            out_nxt   = byte_in;
            state_nxt = ST_DONE;
            done_nxt  = 1'b1;
          end
          default: ;
        endcase
      end
    end else if (edge_ok && sck_fall &&
                 (state_r == ST_RDATA || state_r == ST_STAT)) begin
      so_nxt  = out_r[7];
      out_nxt = {out_r[6:0], 1'b0};
      if (bcnt_r == 3'd7) begin
        if (state_r == ST_RDATA) begin
          addr_nxt = addr_r + 16'd1;
          out_nxt  = mem[addr_r + 16'd1];
        end else begin
          out_nxt = status;
        end
      end
    end

    // output enable follows hold directly, independent of the clock
    so_oe_n_nxt = !(!cs_s && hold_s &&
                    (state_nxt == ST_RDATA || state_nxt == ST_STAT));
    standby_nxt = cs_s && !wip_nxt;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ST_IDLE;  bcnt_r <= 3'd0;  sh_r <= 8'h00;  op_r <= 8'h00;
      out_r <= 8'h00;  abyte_r <= 1'b0;  done_r <= 1'b0;  addr_r <= '0;
      col_r <= '0;  paused_r <= 1'b0;  wel_r <= 1'b0;  wip_r <= 1'b0;
      erase_r <= 1'b0;  ppe_r <= PPE_RESET;  bp_r <= BP_RESET;  tmr_r <= '0;
      cidx_r <= '0;  pvalid_r <= '0;  so <= 1'b0;  so_oe_n <= 1'b1;
      standby <= 1'b1;
    end else begin
      state_r <= state_nxt;  bcnt_r <= bcnt_nxt;  sh_r <= sh_nxt;  op_r <= op_nxt;
      out_r <= out_nxt;  abyte_r <= abyte_nxt;  done_r <= done_nxt;
      addr_r <= addr_nxt;  col_r <= col_nxt;  paused_r <= paused_nxt;
      wel_r <= wel_nxt;  wip_r <= wip_nxt;  erase_r <= erase_nxt;
      ppe_r <= ppe_nxt;  bp_r <= bp_nxt;  tmr_r <= tmr_nxt;  cidx_r <= cidx_nxt;
      pvalid_r <= pvalid_nxt;  so <= so_nxt;  so_oe_n <= so_oe_n_nxt;
      standby <= standby_nxt;
    end
  end

  // ==================================================
  // array and page buffer writes; contents have no reset
  always_ff @(posedge clk) begin
    if (mem_we) mem[mem_wa] <= mem_wd;
    if (pbuf_we) pbuf[col_r] <= byte_in;
  end

endmodule

`default_nettype wire

// ### ees_spi_eeprom_sva.sv
`timescale 1ns/1ns
`default_nettype none
module ees_spi_eeprom_sva #(
  parameter int TWC_CYCLES = ees_pkg::WRITE_CYCLE_CLKS
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic hold_n,
  input wire logic wp_n,
  input wire logic so,
  input wire logic so_oe_n,
  input wire logic standby
);
  localparam int TW_MIN = TWC_CYCLES - 4;
  localparam int TW_MAX = TWC_CYCLES + 12;
  logic [31:0] wcnt_r;
  logic [31:0] wcnt_nxt;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // ==========================================
  // time since release while still not in standby; a frame during the cycle keeps counting
  always_comb begin
    wcnt_nxt = 32'h0;
    if (!standby && (cs_n || wcnt_r != 32'h0)) begin
      wcnt_nxt = wcnt_r + 32'h1;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wcnt_r <= 32'h0;
    end else begin
      wcnt_r <= wcnt_nxt;
    end
  end
  sequence s_deselected;
    cs_n[*4];
  endsequence
  sequence s_held;
    !hold_n[*7];
  endsequence
  // ==========================================
  // assertions
  a_desel_hiz: assert property (s_deselected |-> so_oe_n)
    else $error("output driven while deselected");
  a_hold_hiz: assert property (!hold_n[*4] |-> so_oe_n)
    else $error("output driven while paused");
  a_hold_still: assert property (s_held |-> $stable(so))
    else $error("output moved while paused");
  a_sel_active: assert property (!cs_n[*4] |-> !standby)
    else $error("standby while selected");
  a_sel_wake: assert property ($fell(cs_n) |-> ##[2:4] !standby)
    else $error("select did not leave standby");
  a_cycle_len: assert property ($rose(standby) |-> wcnt_r < 8 || wcnt_r >= TW_MIN)
    else $error("write cycle ended early");
  a_cycle_max: assert property (wcnt_r <= TW_MAX)
    else $error("write cycle overran");
  a_so_on_fall: assert property ($changed(so) && !so_oe_n && !$past(so_oe_n)
    |-> !$past(sck, 3))
    else $error("output changed away from clock fall");
endmodule
bind ees_spi_eeprom ees_spi_eeprom_sva #(.TWC_CYCLES(TWC_CYCLES)) u_sva (.clk(clk),
  .arst_n(arst_n), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n), .wp_n(wp_n),
  .so(so), .so_oe_n(so_oe_n), .standby(standby));
`default_nettype wire

// ### ees_host.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// spi host model; clock stands still outside frames
module ees_host #(
  parameter int HP = 5
) (
  input  wire logic       clk,
  output var  logic       cs_n,
  output var  logic       sck,
  output var  logic       si,
  output var  logic       hold_n,
  input  wire logic       so,
  input  wire logic       so_oe_n,
  output var  logic [7:0] rd_byte,
  output var  logic       rd_vld
);
  initial begin
    {cs_n, sck, si, hold_n, rd_vld} = 5'h12;
    rd_byte = 8'h00;
  end
  task automatic sel();
    cs_n <= 1'b0;
    repeat (HP) @(posedge clk);
  endtask
  // released data line flips so a stale level is never read as valid
  task automatic desel();
    cs_n <= 1'b1;
    si   <= ~si;
    repeat (8) @(posedge clk);
  endtask
  // n bits msb first, optional pause before bit hb
  task automatic xb(input logic [7:0] d, input int n, input int hb, input bit chk);
    logic [7:0] q;
    q = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      if (i == hb) begin
        // let the last clock fall land before pausing with the clock low
        repeat (HP) @(posedge clk);
        hold_n <= 1'b0;
        repeat (HP) @(posedge clk);
        sck <= 1'b1;
        si  <= ~si;
        repeat (HP) @(posedge clk);
        sck <= 1'b0;
        repeat (HP) @(posedge clk);
        hold_n <= 1'b1;
      end
      si <= d[i];
      repeat (HP) @(posedge clk);
      q[i] = so_oe_n ? 1'bz : so;
      sck <= 1'b1;
      repeat (HP) @(posedge clk);
      sck <= 1'b0;
    end
    rd_byte <= q;
    rd_vld  <= chk;
    @(posedge clk);
    rd_vld <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### ees_spi_eeprom_tb.sv
`timescale 1ns/1ns
`default_nettype none
module ees_spi_eeprom_tb;
  import ees_pkg::*;
  localparam int TWC = 800;
  logic clk, arst_n, wp_n, so, so_oe_n, standby, cs_n, sck, si, hold_n, rd_vld;
  logic [7:0] rd_byte, e;
  logic [7:0] mem [0:65535];
  logic [7:0] exp_q [$];
  logic [7:0] nop [4] = '{CMD_ZONE_CLEAR, CMD_CHIP_ERASE, CMD_WAKE_AND_SIGNATURE,
                          CMD_SLEEP_DEEP};
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  ees_spi_eeprom #(.TWC_CYCLES(TWC)) i_ees_spi_eeprom (.clk(clk), .arst_n(arst_n),
    .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n), .wp_n(wp_n), .so(so),
    .so_oe_n(so_oe_n), .standby(standby));
  ees_host u_host (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n),
    .so(so), .so_oe_n(so_oe_n), .rd_byte(rd_byte), .rd_vld(rd_vld));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ==========================================
  // watcher and hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rd_vld === 1'b1) begin
      e = exp_q.pop_front();
      n_checks++;
      if (rd_byte !== e) begin
        n_errors++;
        $display("unexpected read byte: expected %h seen %h", e, rd_byte);
      end
    end
    if (cyc == 30000) begin
      n_errors++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ==========================================
  // frame helpers
  task automatic cmd(input logic [7:0] op);
    u_host.sel();
    u_host.xb(op, 8, -1, 1'b0);
    u_host.desel();
  endtask
  task automatic stat(input logic [7:0] x, input int hb);
    exp_q.push_back(x);
    u_host.sel();
    u_host.xb(CMD_READ_STATUS, 8, -1, 1'b0);
    u_host.xb(8'h00, 8, hb, 1'b1);
    u_host.desel();
  endtask
  task automatic hdr(input logic [7:0] op, input logic [15:0] a);
    u_host.sel();
    u_host.xb(op, 8, -1, 1'b0);
    u_host.xb(a[15:8], 8, -1, 1'b0);
    u_host.xb(a[7:0], 8, -1, 1'b0);
  endtask
  task automatic wt();
    for (int k = 0; k < 1000 && standby !== 1'b1; k++) @(posedge clk);
    n_checks++;
    if (standby !== 1'b1) begin
      n_errors++;
      $display("unexpected standby: expected 1 seen %b", standby);
      complete_run();
    end
  endtask
  // write does not wait, so a busy window can be probed
  task automatic wr(input logic [15:0] a, input int n);
    logic [7:0] d;
    cmd(CMD_SET_WRITE_LATCH);
    hdr(CMD_WRITE, a);
    for (int k = 0; k < n; k++) begin
      d = 8'($urandom());
      mem[{a[15:7], 7'(a[6:0] + k)}] = d;
      u_host.xb(d, 8, -1, 1'b0);
    end
    u_host.desel();
  endtask
  task automatic rd(input logic [15:0] a, input int n, input bit z);
    hdr(CMD_READ, a);
    for (int k = 0; k < n; k++) begin
      exp_q.push_back(z ? 8'hzz : mem[16'(a + k)]);
      u_host.xb(8'h00, 8, -1, 1'b1);
    end
    u_host.desel();
  endtask
  task automatic wsr(input logic [7:0] v, input bit drop_wp);
    cmd(CMD_SET_WRITE_LATCH);
    u_host.sel();
    u_host.xb(CMD_WRITE_STATUS, 8, -1, 1'b0);
    u_host.xb(v, 8, -1, 1'b0);
    u_host.desel();
    if (drop_wp) wp_n <= 1'b0;
    wt();
  endtask
  // ==========================================
  // main sequence
  initial begin
    {arst_n, wp_n} = 2'b01;
    void'($urandom(38003));
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    stat(8'h00, -1);
    cmd(CMD_SET_WRITE_LATCH);
    stat(8'h02, 3);
    cmd(CMD_CLEAR_WRITE_LATCH);
    stat(8'h00, -1);
    $display("latch test done");
    wr(16'hfffe, 3);
    stat(8'h03, -1);
    rd(16'hfffe, 1, 1'b1);
    wt();
    wr(16'h0000, 1);
    wt();
    stat(8'h00, -1);
    rd(16'hfffe, 3, 1'b0);
    rd(16'hff80, 1, 1'b0);
    cmd(CMD_SET_WRITE_LATCH);
    hdr(CMD_WRITE, 16'h0000);
    u_host.xb(8'h5a, 8, -1, 1'b0);
    u_host.xb(8'ha5, 4, -1, 1'b0);
    u_host.desel();
    stat(8'h02, -1);
    rd(16'h0000, 1, 1'b0);
    $display("array test done");
    hdr(CMD_PAGE_ERASE, 16'hff80);
    u_host.desel();
    wt();
    for (int k = 0; k < 128; k++) mem[{9'h1ff, 7'(k)}] = ERASED_BYTE;
    rd(16'hfffe, 3, 1'b0);
    foreach (nop[k]) cmd(nop[k]);
    stat(8'h00, -1);
    $display("erase test done");
    wsr(8'h8c, 1'b0);
    stat(8'h8c, -1);
    wp_n <= 1'b0;
    wsr(8'h00, 1'b0);
    stat(8'h8e, -1);
    wp_n <= 1'b1;
    wsr(8'h00, 1'b1);
    stat(8'h00, -1);
    wp_n <= 1'b0;
    wsr(8'h04, 1'b0);
    stat(8'h04, -1);
    $display("status test done");
    complete_run();
  end
endmodule
`default_nettype wire
